//--- logic/iex_core.sv
`timescale 1ns/10ps
// Contract
// - Watchdog clear zeroes the counter and clears sleep and expired flags.
// - Both preclear halves executed together clear counter and both flags.
// - A lone preclear only records itself; counter and flags stay.
// - Complement inverts the byte into memory or working register; zero flag.
// - Low nibble above 9 or nibble carry adds 6; the carry out of that sum is the adjust carry.
// - High nibble plus adjust carry gets 6 and carry when above 9 or carry.
// - Decrement subtracts one into memory or working register; zero flag only.
// - Increment adds one into memory or working register; zero flag only.
// - Power-down stops execution and clock, keeping memory and registers.
// - Power-down advances the counter, clears watchdog, sets sleep, clears expired.
// - Direct jump loads the program counter from the instruction; no flags.
// - Move to working copies memory byte or immediate; no flags.
// - Move to memory copies the working register; no flags.
// - No-operation only advances the program counter.
// - OR combines working register with byte or immediate; zero flag only.
// - Subroutine return pops the program counter in two instruction cycles.
// - Return with value pops the counter and loads the immediate.
// - Interrupt return pops the counter and sets global interrupt enable.
// - Rotate left moves bit 7 into bit 0 in place; no flags.
// - Rotate left to working leaves memory alone; no flags.
// - A write to program counter low costs one extra instruction cycle.
module iex_core
   import iex_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Core state.
   input wire logic wdt_tick_i,
   output logic [PC_W-1:0] pc_o,
   output logic [DATA_W-1:0] acc_o,
   output logic halted_o,
   output logic clk_gate_o
);
   // Internal data memory of the core.
   logic [DATA_W-1:0] ram_ff [2**ADDR_W];
   iex_instr_t instr_ff;
   iex_flags_t flg_ff, nxt_flg;
   logic [DATA_W-1:0] acc_ff, nxt_acc, mem_wd, m;
   logic [PC_W-1:0] pc_ff, nxt_pc, top;
   logic [WDT_W-1:0] wdt_ff;
   logic [PRE_W-1:0] pre_ff;
   logic [31:0] dat_ff;
   logic [4:0] wait_ff, len, lo_sum, hi_sum;
   logic pre1_ff, pre2_ff, ack_ff, go, mem_we, wdt_clr, push, pop, ac1, op_ok;
   // Execution FSM states.
   typedef enum logic [2:0] {
      S_IDLE = 3'b001, S_WAIT = 3'b010, S_HALT = 3'b100
   } iex_st_t;
   iex_st_t st_ff;
   assign m = ram_ff[instr_ff.addr];
   assign op_ok = (instr_ff.op <= OP_PUSH);
   // A write to the control register fires the staged instruction.
   assign go = cyc_i && stb_i && we_i && !ack_ff && adr_i == REG_CTRL && sel_i[0] && dat_i[0]
      && st_ff == S_IDLE && op_ok;
   // Decimal adjust nibble arithmetic.
   always_comb begin
      lo_sum = {1'b0, acc_ff[3:0]};
      ac1 = 1'b0;
      if (acc_ff[3:0] > BCD_MAX || flg_ff.ac) begin
         lo_sum = {1'b0, acc_ff[3:0]} + {1'b0, BCD_FIX};
         ac1 = lo_sum[4];
      end
      hi_sum = {1'b0, acc_ff[7:4]} + {4'h0, ac1};
   end
   // Instruction execution decode.
   always_comb begin
      nxt_flg = flg_ff;
      nxt_acc = acc_ff;
      nxt_pc = pc_ff + 11'h001;
      mem_we = 1'b0;
      mem_wd = m;
      wdt_clr = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      len = 5'(CLKS_PER_ICYC);
      case (instr_ff.op)
         OP_CLRWDT: begin
            wdt_clr = 1'b1;
            nxt_flg.to = 1'b0;
            nxt_flg.sleep_entered_flag = 1'b0;
         end
         OP_PRE1, OP_PRE2: begin
            if ((instr_ff.op == OP_PRE1) ? pre2_ff : pre1_ff) begin
               wdt_clr = 1'b1;
               nxt_flg.to = 1'b0;
               nxt_flg.sleep_entered_flag = 1'b0;
            end
         end
         OP_CPL, OP_COMPLEMENT_TO_WORKING: begin
            nxt_flg.z = (~m == 8'h00);
            if (instr_ff.op == OP_CPL) begin
               mem_we = 1'b1;
               mem_wd = ~m;
            end else begin
               nxt_acc = ~m;
            end
         end
         OP_DADJ: begin
            mem_we = 1'b1;
            if (hi_sum > {1'b0, BCD_MAX} || flg_ff.c) begin
               mem_wd = {4'(hi_sum[3:0] + BCD_FIX), lo_sum[3:0]};
               nxt_flg.c = 1'b1;
            end else begin
               mem_wd = {hi_sum[3:0], lo_sum[3:0]};
            end
         end
         OP_DEC, OP_DECREMENT_TO_WORKING: begin
            nxt_flg.z = (m == 8'h01);
            if (instr_ff.op == OP_DEC) begin
               mem_we = 1'b1;
               mem_wd = m - 8'h01;
            end else begin
               nxt_acc = m - 8'h01;
            end
         end
         OP_INC, OP_INCREMENT_TO_WORKING: begin
            nxt_flg.z = (m == 8'hff);
            if (instr_ff.op == OP_INC) begin
               mem_we = 1'b1;
               mem_wd = m + 8'h01;
            end else begin
               nxt_acc = m + 8'h01;
            end
         end
         OP_HALT: begin
            wdt_clr = 1'b1;
            nxt_flg.sleep_entered_flag = 1'b1;
            nxt_flg.to = 1'b0;
         end
         OP_JUMP: begin
            nxt_pc = instr_ff.target;
            len = 5'(2 * CLKS_PER_ICYC);
         end
         OP_MOVAM: nxt_acc = m;
         OP_MOVAX: nxt_acc = instr_ff.imm;
         OP_MOVMA: begin
            mem_we = 1'b1;
            mem_wd = acc_ff;
         end
         OP_ORAM, OP_ORM: begin
            nxt_flg.z = ((acc_ff | m) == 8'h00);
            if (instr_ff.op == OP_ORM) begin
               mem_we = 1'b1;
               mem_wd = acc_ff | m;
            end else begin
               nxt_acc = acc_ff | m;
            end
         end
         OP_ORAX: begin
            nxt_acc = acc_ff | instr_ff.imm;
            nxt_flg.z = ((acc_ff | instr_ff.imm) == 8'h00);
         end
         OP_RET, OP_RETX, OP_INTERRUPT_RETURN: begin
            pop = 1'b1;
            nxt_pc = top;
            len = 5'(2 * CLKS_PER_ICYC);
            if (instr_ff.op == OP_RETX) begin
               nxt_acc = instr_ff.imm;
            end
            if (instr_ff.op == OP_INTERRUPT_RETURN) begin
               nxt_flg.global_interrupt_enable = 1'b1;
            end
         end
         OP_RL: begin
            mem_we = 1'b1;
            mem_wd = {m[6:0], m[7]};
         end
         OP_RLA: nxt_acc = {m[6:0], m[7]};
         OP_PUSH: push = 1'b1;
         default: begin
         end
      endcase
      // Program counter low write reloads the pipeline.
      if (mem_we && instr_ff.addr == 7'h00) begin
         len = len + 5'(CLKS_PER_ICYC);
         nxt_pc = {pc_ff[PC_W-1:DATA_W], mem_wd};
      end
   end
   iex_stack u_stack (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(go && push),
      .pop_i(go && pop),
      .data_i(pc_ff + 11'h001),
      .top_o(top)
   );
   // Memory write; contents survive power-down.
   always_ff @(posedge clk_i) begin
      if (go && mem_we) begin
         ram_ff[instr_ff.addr] <= mem_wd;
      end
   end
   // Architectural registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_ff <= RST_BYTE;
         pc_ff <= RST_PC;
         flg_ff <= '0;
      end else if (go) begin
         acc_ff <= nxt_acc;
         pc_ff <= nxt_pc;
         flg_ff <= nxt_flg;
      end
   end
   // Preclear half tracking; a completed pair rearms both.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre1_ff <= 1'b0;
         pre2_ff <= 1'b0;
      end else if (go && wdt_clr) begin
         pre1_ff <= 1'b0;
         pre2_ff <= 1'b0;
      end else if (go && instr_ff.op == OP_PRE1) begin
         pre1_ff <= 1'b1;
      end else if (go && instr_ff.op == OP_PRE2) begin
         pre2_ff <= 1'b1;
      end
   end
   // Watchdog and prescaler; the count freezes while halted.
   always_ff @(posedge clk_i) begin
      if (rst_i || (go && wdt_clr)) begin
         wdt_ff <= RST_BYTE;
         pre_ff <= 7'h00;
      end else if (wdt_tick_i && st_ff != S_HALT) begin
         pre_ff <= pre_ff + 7'h01;
         if (pre_ff == 7'h7f) begin
            wdt_ff <= wdt_ff + 8'h01;
         end
      end
   end
   // Sequencer: busy for the instruction length, halt until reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= S_IDLE;
         wait_ff <= 5'h00;
      end else begin
         case (st_ff)
            S_IDLE: begin
               if (go) begin
                  st_ff <= (instr_ff.op == OP_HALT) ? S_HALT : S_WAIT;
                  wait_ff <= len - 5'h1;
               end
            end
            S_WAIT: begin
               wait_ff <= wait_ff - 5'h1;
               if (wait_ff == 5'h1) begin
                  st_ff <= S_IDLE;
               end
            end
            S_HALT: st_ff <= S_HALT;
            default: st_ff <= S_IDLE;
         endcase
      end
   end
   // Staging registers for the instruction.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         instr_ff <= '0;
      end else if (cyc_i && stb_i && we_i && !ack_ff) begin
         if (adr_i == REG_INSTR && sel_i[0]) begin
            instr_ff.op <= iex_op_t'(dat_i[4:0]);
         end
         if (adr_i == REG_INSTR && sel_i[1]) begin
            instr_ff.addr <= dat_i[14:8];
         end
         if (adr_i == REG_OPND && sel_i[0]) begin
            instr_ff.imm <= dat_i[7:0];
         end
         if (adr_i == REG_OPND && sel_i[2]) begin
            instr_ff.target[7:0] <= dat_i[23:16];
         end
         if (adr_i == REG_OPND && sel_i[3]) begin
            instr_ff.target[PC_W-1:8] <= dat_i[26:24];
         end
      end
   end
   // One-wait-state Wishbone answer; unmapped reads return zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= cyc_i && stb_i && !ack_ff;
         case (adr_i)
            REG_INSTR: dat_ff <= {17'h0_0000, instr_ff.addr, 3'h0, instr_ff.op};
            REG_OPND: dat_ff <= {5'h00, instr_ff.target, 8'h00, instr_ff.imm};
            REG_CTRL: dat_ff <= {5'h00, pc_ff, wdt_ff, acc_ff};
            REG_STAT: dat_ff <= {24'h00_0000, st_ff != S_IDLE, flg_ff.global_interrupt_enable, flg_ff.to,
               flg_ff.sleep_entered_flag, flg_ff.ov, flg_ff.z, flg_ff.ac, flg_ff.c};
            default: dat_ff <= 32'h0000_0000;
         endcase
      end
   end
   // Output flops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halted_o <= 1'b0;
         clk_gate_o <= 1'b0;
      end else begin
         halted_o <= (st_ff == S_HALT);
         clk_gate_o <= (st_ff == S_HALT);
      end
   end
   // Outputs are driven straight from their flops.
   assign ack_o = ack_ff;
   assign dat_o = dat_ff;
   assign pc_o = pc_ff;
   assign acc_o = acc_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_clrwdt;
      go && instr_ff.op == OP_CLRWDT |=> wdt_ff == 8'h00 && !flg_ff.to && !flg_ff.sleep_entered_flag;
   endproperty
   a_clrwdt: assert property (p_clrwdt) else $error("watchdog clear failed");
   property p_pair;
      go && instr_ff.op == OP_PRE2 && pre1_ff |=> wdt_ff == 8'h00 && !flg_ff.sleep_entered_flag;
   endproperty
   a_pair: assert property (p_pair) else $error("preclear pair failed");
   property p_lone;
      go && instr_ff.op == OP_PRE1 && !pre2_ff |=> $stable(flg_ff.sleep_entered_flag) && pre1_ff;
   endproperty
   a_lone: assert property (p_lone) else $error("lone preclear changed flags");
   property p_increment_to_working;
      go && instr_ff.op == OP_INCREMENT_TO_WORKING |=> acc_ff == $past(m) + 8'h01 && $stable(flg_ff.c);
   endproperty
   a_increment_to_working: assert property (p_increment_to_working) else $error("increment to working wrong");
   property p_halt;
      go && instr_ff.op == OP_HALT |=> flg_ff.sleep_entered_flag && !flg_ff.to ##1 halted_o [*3];
   endproperty
   a_halt: assert property (p_halt) else $error("power-down entry wrong");
   property p_jump;
      go && instr_ff.op == OP_JUMP |=> pc_ff == $past(instr_ff.target);
   endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");
   property p_ret_len;
      go && instr_ff.op == OP_RET && !(mem_we && instr_ff.addr == 7'h00)
         |=> st_ff == S_WAIT [*7] ##1 st_ff == S_IDLE;
   endproperty
   a_ret_len: assert property (p_ret_len) else $error("return length wrong");
   property p_interrupt_return;
      go && instr_ff.op == OP_INTERRUPT_RETURN |=> flg_ff.global_interrupt_enable && pc_ff == $past(top);
   endproperty
   a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt return wrong");
   property p_rla;
      go && instr_ff.op == OP_RLA |=> acc_ff == {$past(m[6:0]), $past(m[7])};
   endproperty
   a_rla: assert property (p_rla) else $error("rotate to working wrong");
   property p_pcl_len;
      go && instr_ff.op == OP_MOVMA && instr_ff.addr == 7'h00
         |=> (st_ff == S_WAIT) [*7] ##1 st_ff == S_IDLE;
   endproperty
   a_pcl_len: assert property (p_pcl_len) else $error("counter low write length wrong");
   c_pair: cover property (go && instr_ff.op == OP_PRE2 && pre1_ff);
   c_halt: cover property (go && instr_ff.op == OP_HALT);
   c_interrupt_return: cover property (go && instr_ff.op == OP_INTERRUPT_RETURN);
   c_pcl: cover property (go && mem_we && instr_ff.addr == 7'h00);
endmodule : iex_core

//--- logic/iex_pkg.sv
package iex_pkg;
   // Instruction word and data widths of the core.
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam int ADDR_W = 7;
   localparam int STACK_DEPTH = 4;
   localparam int WDT_W = 8;
   localparam int PRE_W = 7;
   // Timing: system clocks per instruction cycle.
   localparam int CLKS_PER_ICYC = 4;
   // Decimal adjust constants.
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;
   // Wishbone register word offsets (byte addresses).
   localparam logic [3:0] REG_INSTR = 4'h0;
   localparam logic [3:0] REG_OPND = 4'h4;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hc;
   // Status field positions in REG_STAT.
   localparam int ST_C = 0;
   localparam int ST_AC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   localparam int ST_PDF = 4;
   localparam int ST_TO = 5;
   localparam int ST_EMI = 6;
   localparam int ST_BUSY = 7;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [PC_W-1:0] RST_PC = 11'h000;

   // Opcodes accepted by the execution unit.
   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_CLRWDT = 5'h01, OP_PRE1 = 5'h02, OP_PRE2 = 5'h03,
      OP_CPL = 5'h04, OP_COMPLEMENT_TO_WORKING = 5'h05, OP_DADJ = 5'h06, OP_DEC = 5'h07,
      OP_DECREMENT_TO_WORKING = 5'h08, OP_INC = 5'h09, OP_INCREMENT_TO_WORKING = 5'h0a, OP_HALT = 5'h0b,
      OP_JUMP = 5'h0c, OP_MOVAM = 5'h0d, OP_MOVAX = 5'h0e, OP_MOVMA = 5'h0f,
      OP_ORAM = 5'h10, OP_ORAX = 5'h11, OP_ORM = 5'h12, OP_RET = 5'h13,
      OP_RETX = 5'h14, OP_INTERRUPT_RETURN = 5'h15, OP_RL = 5'h16, OP_RLA = 5'h17,
      OP_PUSH = 5'h18
   } iex_op_t;

   // One instruction as presented to the core.
   typedef struct packed {
      iex_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] imm;
      logic [PC_W-1:0] target;
   } iex_instr_t;

   // Status flags of the core.
   typedef struct packed {
      logic global_interrupt_enable;
      logic to;
      logic sleep_entered_flag;
      logic ov;
      logic z;
      logic ac;
      logic c;
   } iex_flags_t;
endpackage : iex_pkg

//--- logic/iex_stack.sv
`timescale 1ns/10ps
// Last-in first-out return address stack.
module iex_stack
   import iex_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Push and pop strobes.
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [PC_W-1:0] data_i,
   // Top of stack.
   output logic [PC_W-1:0] top_o
);
   logic [PC_W-1:0] mem_ff [STACK_DEPTH];
   logic [1:0] ptr_ff;

   // Pointer wraps, so overflow overwrites the oldest entry.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ptr_ff <= 2'h0;
      end else if (push_i) begin
         ptr_ff <= ptr_ff + 2'h1;
      end else if (pop_i) begin
         ptr_ff <= ptr_ff - 2'h1;
      end
   end

   // Entries are written at the pointer on push.
   always_ff @(posedge clk_i) begin
      if (push_i) begin
         mem_ff[ptr_ff] <= data_i;
      end
   end

   // Top entry sits one below the pointer.
   assign top_o = mem_ff[ptr_ff - 2'h1];
endmodule : iex_stack

//--- tb/iex_wb_master.sv
`timescale 1ns/10ps
// Bus master that stands in for the software driving the core's register port.
module iex_wb_master (
   // Clock.
   input wire logic clk_i,
   // Wishbone master side.
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [3:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   input wire logic [31:0] dat_i,
   input wire logic ack_i
);
   // The bus is idle from time zero.
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 4'h0;
      sel_o = 4'hf;
      dat_o = 32'h0000_0000;
   end

   // One classic cycle; the request is held until ack is sampled high at a rising edge or 64 edges have passed.
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic late);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 64);
      q = dat_i;
      late = (n >= 64);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
   endtask : xfer
endmodule : iex_wb_master

//--- tb/mcu_instr_exec_subset_bench.sv
`timescale 1ns/10ps
// Self-checking bench: every instruction is run, then counter, watchdog, working register and flags are compared.
module mcu_instr_exec_subset_bench;
   import iex_pkg::*;
   // Clock, reset and wires.
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wdt_tick_i = 1'b0;
   logic cyc, stb, we, ack, halted, gate;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat;
   logic [PC_W-1:0] pc, epc;
   logic [DATA_W-1:0] acc, eacc, ewdt, est;
   int n_errors = 0;
   int comparisons = 0;

   // System clock of 100 MHz.
   always #5 clk_i = ~clk_i;

   // Register port master and the core.
   iex_wb_master m (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
      .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
   iex_core uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .wdt_tick_i(wdt_tick_i), .pc_o(pc), .acc_o(acc), .halted_o(halted), .clk_gate_o(gate));

   // Compare one value and count the result.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Print the counts and the verdict, then stop.
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // One bus access; a missing ack ends the run.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      logic late;
      m.xfer(w, a, d, q, late);
      if (late) begin
         n_errors++;
         $display("[ERR] ack expected 1 seen 0");
         print_verdict();
      end
   endtask : bus

   // Compare counter, watchdog, working register and flags with the expectation.
   task automatic state();
      logic [31:0] q;
      bus(1'b0, REG_CTRL, 32'h0000_0000, q);
      check("core word", q, {5'h00, epc, ewdt, eacc});
      bus(1'b0, REG_STAT, 32'h0000_0000, q);
      check("status", q, {24'h00_0000, est});
      check("pc pin", 32'(pc), 32'(epc));
      check("acc pin", 32'(acc), 32'(eacc));
   endtask : state

   // Load and execute one instruction, wait for busy to clear, then compare.
   task automatic run(input iex_op_t op, input logic [6:0] a, input logic [7:0] x,
                      input logic [10:0] t);
      logic [31:0] q;
      int n;
      if (op == OP_MOVMA && a == 7'h00) begin
         epc = {epc[PC_W-1:8], eacc};
      end else if (!(op inside {OP_JUMP, OP_RET, OP_RETX, OP_INTERRUPT_RETURN})) begin
         epc = epc + 11'h001;
      end
      bus(1'b1, REG_INSTR, {17'h0_0000, a, 3'h0, op}, q);
      bus(1'b1, REG_OPND, {5'h00, t, 8'h00, x}, q);
      bus(1'b1, REG_CTRL, 32'h0000_0001, q);
      n = 0;
      q = 32'h0000_0080;
      while (q[ST_BUSY] !== 1'b0 && n < 20) begin
         bus(1'b0, REG_STAT, 32'h0000_0000, q);
         n++;
      end
      if (n >= 20) begin
         n_errors++;
         $display("[ERR] busy expected 0 seen 1");
         print_verdict();
      end
      state();
   endtask : run

   // Run a data instruction with its expected working register and zero flag.
   task automatic step(input iex_op_t op, input logic [6:0] a, input logic [7:0] x,
                       input logic [7:0] ea, input logic ez);
      eacc = ea;
      est[ST_Z] = ez;
      run(op, a, x, 11'h000);
   endtask : step

   // Watchdog clock enable pulses.
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_i);
         wdt_tick_i <= 1'b1;
         @(posedge clk_i);
         wdt_tick_i <= 1'b0;
      end
   endtask : ticks

   // Reset state, an unmapped read and a write to the read-only status word.
   task automatic t_reset();
      logic [31:0] q;
      state();
      bus(1'b0, 4'h2, 32'h0000_0000, q);
      check("unmapped read", q, 32'h0000_0000);
      bus(1'b1, REG_STAT, 32'h0000_007f, q);
      state();
      $display("test reset done");
   endtask : t_reset

   // Moves, complement, OR, increment, decrement and rotate.
   task automatic t_data();
      step(OP_MOVAX, 7'h00, 8'h5a, 8'h5a, 1'b0);
      step(OP_MOVMA, 7'h10, 8'h00, 8'h5a, 1'b0);
      step(OP_MOVAX, 7'h00, 8'h00, 8'h00, 1'b0);
      step(OP_MOVAM, 7'h10, 8'h00, 8'h5a, 1'b0);
      step(OP_COMPLEMENT_TO_WORKING, 7'h10, 8'h00, 8'ha5, 1'b0);
      step(OP_MOVAM, 7'h10, 8'h00, 8'h5a, 1'b0);
      step(OP_CPL, 7'h10, 8'h00, 8'h5a, 1'b0);
      step(OP_MOVAM, 7'h10, 8'h00, 8'ha5, 1'b0);
      step(OP_MOVAX, 7'h00, 8'h00, 8'h00, 1'b0);
      step(OP_ORAX, 7'h00, 8'h00, 8'h00, 1'b1);
      step(OP_ORM, 7'h10, 8'h00, 8'h00, 1'b0);
      step(OP_ORAX, 7'h00, 8'h5a, 8'h5a, 1'b0);
      step(OP_ORAM, 7'h10, 8'h00, 8'hff, 1'b0);
      step(OP_MOVMA, 7'h11, 8'h00, 8'hff, 1'b0);
      step(OP_INC, 7'h11, 8'h00, 8'hff, 1'b1);
      step(OP_MOVAM, 7'h11, 8'h00, 8'h00, 1'b1);
      step(OP_INCREMENT_TO_WORKING, 7'h11, 8'h00, 8'h01, 1'b0);
      step(OP_MOVAM, 7'h11, 8'h00, 8'h00, 1'b0);
      step(OP_DECREMENT_TO_WORKING, 7'h11, 8'h00, 8'hff, 1'b0);
      step(OP_DEC, 7'h11, 8'h00, 8'hff, 1'b0);
      step(OP_MOVAX, 7'h00, 8'h01, 8'h01, 1'b0);
      step(OP_MOVMA, 7'h11, 8'h00, 8'h01, 1'b0);
      step(OP_DECREMENT_TO_WORKING, 7'h11, 8'h00, 8'h00, 1'b1);
      step(OP_ORAX, 7'h00, 8'h01, 8'h01, 1'b0);
      step(OP_DEC, 7'h11, 8'h00, 8'h01, 1'b1);
      step(OP_MOVAX, 7'h00, 8'h81, 8'h81, 1'b1);
      step(OP_MOVMA, 7'h12, 8'h00, 8'h81, 1'b1);
      step(OP_RLA, 7'h12, 8'h00, 8'h03, 1'b1);
      step(OP_MOVAM, 7'h12, 8'h00, 8'h81, 1'b1);
      step(OP_RL, 7'h12, 8'h00, 8'h81, 1'b1);
      step(OP_MOVAM, 7'h12, 8'h00, 8'h03, 1'b1);
      $display("test data done");
   endtask : t_data

   // Decimal adjust with and without nibble overflow and carry.
   task automatic t_daa();
      step(OP_MOVAX, 7'h00, 8'h45, 8'h45, 1'b1);
      step(OP_DADJ, 7'h20, 8'h00, 8'h45, 1'b1);
      step(OP_MOVAX, 7'h00, 8'h3b, 8'h3b, 1'b1);
      step(OP_DADJ, 7'h21, 8'h00, 8'h3b, 1'b1);
      step(OP_MOVAX, 7'h00, 8'h9a, 8'h9a, 1'b1);
      est[ST_C] = 1'b1;
      step(OP_DADJ, 7'h22, 8'h00, 8'h9a, 1'b1);
      step(OP_MOVAM, 7'h20, 8'h00, 8'h45, 1'b1);
      step(OP_MOVAM, 7'h21, 8'h00, 8'h41, 1'b1);
      step(OP_MOVAM, 7'h22, 8'h00, 8'h00, 1'b1);
      step(OP_DADJ, 7'h23, 8'h00, 8'h00, 1'b1);
      step(OP_MOVAM, 7'h23, 8'h00, 8'h60, 1'b1);
      $display("test decimal adjust done");
   endtask : t_daa

   // Watchdog clear and the preclear pair, lone and repeated halves.
   task automatic t_wdt();
      ticks(256);
      ewdt = 8'h02;
      run(OP_NOP, 7'h00, 8'h00, 11'h000);
      run(OP_PRE1, 7'h00, 8'h00, 11'h000);
      ticks(128);
      ewdt = 8'h03;
      run(OP_PRE1, 7'h00, 8'h00, 11'h000);
      ewdt = 8'h00;
      run(OP_PRE2, 7'h00, 8'h00, 11'h000);
      ticks(128);
      ewdt = 8'h01;
      run(OP_PRE2, 7'h00, 8'h00, 11'h000);
      ewdt = 8'h00;
      run(OP_CLRWDT, 7'h00, 8'h00, 11'h000);
      $display("test watchdog done");
   endtask : t_wdt

   // Jumps, nested returns in stack order and a write to the counter low byte.
   task automatic t_flow();
      epc = 11'h123;
      run(OP_JUMP, 7'h00, 8'h00, 11'h123);
      run(OP_PUSH, 7'h00, 8'h00, 11'h000);
      epc = 11'h200;
      run(OP_JUMP, 7'h00, 8'h00, 11'h200);
      run(OP_PUSH, 7'h00, 8'h00, 11'h000);
      epc = 11'h300;
      run(OP_JUMP, 7'h00, 8'h00, 11'h300);
      eacc = 8'h77;
      epc = 11'h201;
      run(OP_RETX, 7'h00, 8'h77, 11'h000);
      epc = 11'h124;
      est[ST_EMI] = 1'b1;
      run(OP_INTERRUPT_RETURN, 7'h00, 8'h00, 11'h000);
      run(OP_PUSH, 7'h00, 8'h00, 11'h000);
      epc = 11'h040;
      run(OP_JUMP, 7'h00, 8'h00, 11'h040);
      epc = 11'h125;
      run(OP_RET, 7'h00, 8'h00, 11'h000);
      step(OP_MOVAX, 7'h00, 8'h34, 8'h34, 1'b1);
      step(OP_MOVMA, 7'h00, 8'h00, 8'h34, 1'b1);
      $display("test flow done");
   endtask : t_flow

   // Power-down, a refused execute while halted, then reset as the way out.
   task automatic t_halt();
      logic [31:0] q;
      ticks(128);
      ewdt = 8'h01;
      run(OP_NOP, 7'h00, 8'h00, 11'h000);
      // Halt never clears busy, so it is issued by hand and not polled.
      epc = epc + 11'h001;
      ewdt = 8'h00;
      est[ST_PDF] = 1'b1;
      est[ST_BUSY] = 1'b1;
      bus(1'b1, REG_INSTR, {27'h000_0000, OP_HALT}, q);
      bus(1'b1, REG_CTRL, 32'h0000_0001, q);
      state();
      check("halted", 32'(halted), 32'h0000_0001);
      check("clock gate", 32'(gate), 32'h0000_0001);
      bus(1'b1, REG_INSTR, {27'h000_0000, OP_MOVAX}, q);
      bus(1'b1, REG_OPND, 32'h0000_00c3, q);
      bus(1'b1, REG_CTRL, 32'h0000_0001, q);
      state();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      epc = 11'h000;
      eacc = 8'h00;
      est = 8'h00;
      state();
      check("halted", 32'(halted), 32'h0000_0000);
      $display("test power-down done");
   endtask : t_halt

   // Main sequence.
   initial begin
      epc = 11'h000;
      eacc = 8'h00;
      ewdt = 8'h00;
      est = 8'h00;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_data();
      t_daa();
      t_wdt();
      t_flow();
      t_halt();
      print_verdict();
   end
endmodule : mcu_instr_exec_subset_bench
